// *** cds_exec.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cds_params.svh"
// executes the complement and decrement-and-skip file instructions
module cds_exec (
    input wire logic core_clk,
    input wire logic resetn,
    input wire cds_pkg::cds_instr_type instr_in,
    output var cds_pkg::cds_phase_type phase_out,
    output var cds_pkg::cds_state_type state_out,
    output logic instr_done,
    output logic [7:0] file_rd_data,
    input wire logic [6:0] file_rd_addr
);
    // ****************************************
    // storage
    // ****************************************
    logic [7:0] file_mem [0:`CDS_FILE_WORDS-1];
    cds_pkg::cds_phase_type phase_q, phase_d;
    logic [13:0] ir_q, ir_d;
    logic ir_valid_q, ir_valid_d;
    logic [7:0] opnd_q, opnd_d;
    logic [7:0] res_q, res_d;
    logic [7:0] acc_q, acc_d;
    logic zero_q, zero_d;
    logic skip_q, skip_d;
    logic nop_q, nop_d;
    logic done_q, done_d;
    logic [7:0] rd_q, rd_d;
    logic wr_en;
    logic [5:0] opc;
    logic dest;
    logic [6:0] addr;
    logic is_comp, is_dec;
    logic in_phase_one, in_phase_two, in_phase_three, in_phase_four;
    logic res_zero;

    // ****************************************
    // decode helpers
    // ****************************************
    // fields come from the latched word, so they stay put from phase two through the next phase one
    assign opc = ir_q[`CDS_OPC_MSB:`CDS_OPC_LSB];
    assign dest = ir_q[`CDS_DEST_BIT];
    assign addr = ir_q[`CDS_ADDR_MSB:0];
    // a cancelled cycle decodes as nothing, so no later phase can act on it
    assign is_comp = ir_valid_q && !nop_q && (opc == `CDS_OPC_COMPLEMENT);
    assign is_dec = ir_valid_q && !nop_q && (opc == `CDS_OPC_DEC_SKIP);
    assign in_phase_one = (phase_q == cds_pkg::PH_ONE);
    assign in_phase_two = (phase_q == cds_pkg::PH_TWO);
    assign in_phase_three = (phase_q == cds_pkg::PH_THREE);
    assign in_phase_four = (phase_q == cds_pkg::PH_FOUR);
    assign res_zero = (res_q == 8'h00);

    // ****************************************
    // phase sequencer
    // ****************************************
    // phases run free; an idle or cancelled cycle still takes all four
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            cds_pkg::PH_ONE: begin
                phase_d = cds_pkg::PH_TWO;
            end
            cds_pkg::PH_TWO: begin
                phase_d = cds_pkg::PH_THREE;
            end
            cds_pkg::PH_THREE: begin
                phase_d = cds_pkg::PH_FOUR;
            end
            cds_pkg::PH_FOUR: begin
                phase_d = cds_pkg::PH_ONE;
            end
            default: begin
                phase_d = cds_pkg::PH_ONE;
            end
        endcase
    end

    // phase register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= cds_pkg::PH_ONE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ****************************************
    // instruction latch and skip control
    // ****************************************
    // the word is taken in phase one only; a pending skip turns that cycle into a no-op
    always_comb begin
        ir_d = ir_q;
        ir_valid_d = ir_valid_q;
        nop_d = nop_q;
        skip_d = skip_q;
        if (in_phase_one) begin
            ir_d = instr_in.word;
            ir_valid_d = instr_in.valid;
            nop_d = skip_q;
            skip_d = 1'b0;
        end
        // set in phase four, cleared in phase one, so set and clear never meet
        if (in_phase_four && is_dec) begin
            skip_d = res_zero;
        end
    end

    // instruction registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ir_q <= `CDS_IR_RESET;
            ir_valid_q <= 1'b0;
            nop_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            ir_q <= ir_d;
            ir_valid_q <= ir_valid_d;
            nop_q <= nop_d;
            skip_q <= skip_d;
        end
    end

    // ****************************************
    // datapath
    // ****************************************
    // operand is captured in phase two, well clear of the phase-four write
    always_comb begin
        opnd_d = opnd_q;
        res_d = res_q;
        if (in_phase_two) begin
            opnd_d = file_mem[addr];
        end
        if (in_phase_three) begin
            if (is_comp) begin
                res_d = ~opnd_q;
            end else if (is_dec) begin
                res_d = opnd_q - 8'h01;
            end
        end
    end

    // datapath registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            opnd_q <= 8'h00;
            res_q <= 8'h00;
        end else begin
            opnd_q <= opnd_d;
            res_q <= res_d;
        end
    end

    // ****************************************
    // destination write and status
    // ****************************************
    // no-op cycles fall through untouched but still pulse done
    always_comb begin
        acc_d = acc_q;
        zero_d = zero_q;
        done_d = 1'b0;
        wr_en = 1'b0;
        if (in_phase_four) begin
            if (is_comp || is_dec) begin
                if (dest) begin
                    wr_en = 1'b1;
                end else begin
                    acc_d = res_q;
                end
            end
            // only complement touches the flag; decrement leaves it alone
            if (is_comp) begin
                zero_d = res_zero;
            end
            done_d = 1'b1;
        end
    end

    // result registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= `CDS_ACC_RESET;
            zero_q <= `CDS_ZERO_RESET;
            done_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            done_q <= done_d;
        end
    end

    // ****************************************
    // file storage
    // ****************************************
    // every entry clears on reset so a read before the first write is defined;
    // this costs a reset net on each byte but keeps the datapath free of unknowns
    for (genvar e = 0; e < `CDS_FILE_WORDS; e++) begin : g_file
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                file_mem[e] <= `CDS_FILE_RESET;
            end else if (wr_en && (addr == 7'(e))) begin
                file_mem[e] <= res_q;
            end
        end
    end

    // ****************************************
    // debug read port
    // ****************************************
    // one cycle of latency keeps the output straight from a flop
    always_comb begin
        rd_d = file_mem[file_rd_addr];
    end

    // debug read register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // all outputs come straight from registers
    assign phase_out = phase_q;
    assign state_out = '{acc: acc_q, zero: zero_q, skip: skip_q};
    assign instr_done = done_q;
    assign file_rd_data = rd_q;
endmodule
`default_nettype wire

// *** cds_exec_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ***
// checker
// ***
module cds_exec_chk (
    input wire logic core_clk,
    input wire logic resetn,
    input wire cds_pkg::cds_instr_type instr_in,
    input wire cds_pkg::cds_phase_type phase_out,
    input wire cds_pkg::cds_state_type state_out,
    input wire logic instr_done,
    input wire logic [7:0] file_rd_data,
    input wire logic [6:0] file_rd_addr
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // phase-one words that really run; a pending skip eats the word
    wire logic go = phase_out == cds_pkg::PH_ONE && instr_in.valid && !state_out.skip;
    wire logic cmp = go && instr_in.word[13:8] == 6'h09;
    wire logic dec = go && instr_in.word[13:8] == 6'h0B;
    sequence cmpl_acc_s;
        cmp && !instr_in.word[7];
    endsequence
    sequence dec_acc_s;
        dec && !instr_in.word[7];
    endsequence
    phase_step_a: assert property (1'b1 |=> phase_out == 2'($past(phase_out) + 2'h1))
        else $error("phase did not advance");
    done_pulse_a: assert property (instr_done == ($past(phase_out) == cds_pkg::PH_FOUR))
        else $error("done pulse misplaced");
    acc_time_a: assert property (!$stable(state_out.acc) |-> phase_out == cds_pkg::PH_ONE)
        else $error("acc changed mid instruction");
    cmpl_zero_a: assert property (cmpl_acc_s |-> ##4 state_out.zero == (state_out.acc == 8'h00))
        else $error("zero flag wrong after complement");
    dec_flag_a: assert property (dec |=> $stable(state_out.zero) [*4])
        else $error("decrement touched zero flag");
    skip_set_a: assert property (dec_acc_s |-> ##4 state_out.skip == (state_out.acc == 8'h00))
        else $error("skip does not follow result");
    nop_hold_a: assert property (phase_out == cds_pkg::PH_ONE && state_out.skip
        |=> ($stable(state_out.acc) && $stable(state_out.zero)) [*4])
        else $error("skipped cycle changed state");
    idle_hold_a: assert property (phase_out == cds_pkg::PH_ONE && !instr_in.valid
        |=> $stable(state_out.acc) [*4])
        else $error("idle cycle changed acc");
endmodule
`default_nettype wire

// *** cds_params.svh ***
`ifndef CDS_PARAMS_SVH
`define CDS_PARAMS_SVH
// ****************************************
// instruction fields, opcodes, file size and reset values
// ****************************************
`define CDS_OPC_MSB 13
`define CDS_OPC_LSB 8
`define CDS_DEST_BIT 7
`define CDS_ADDR_MSB 6
`define CDS_OPC_COMPLEMENT 6'h09
`define CDS_OPC_DEC_SKIP 6'h0B
`define CDS_FILE_WORDS 128
`define CDS_ACC_RESET 8'h00
`define CDS_ZERO_RESET 1'b0
`define CDS_FILE_RESET 8'h00
`define CDS_IR_RESET 14'h0000
`endif

// *** cds_pkg.sv ***
package cds_pkg;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } cds_phase_type;

    typedef struct packed {
        logic [13:0] word;
        logic valid;
    } cds_instr_type;

    typedef struct packed {
        logic [7:0] acc;
        logic zero;
        logic skip;
    } cds_state_type;
endpackage

// *** complement_decrement_skip_exec_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
// ***
// bench
// ***
module complement_decrement_skip_exec_tb;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    cds_pkg::cds_instr_type instr_in = '0;
    logic [6:0] file_rd_addr = 7'h00;
    cds_pkg::cds_phase_type phase_out;
    cds_pkg::cds_state_type state_out;
    logic instr_done;
    logic [7:0] file_rd_data;
    logic [7:0] f;
    logic [7:0] a0;
    logic z;
    int err_total = 0;
    int cmp_count = 0;
    bit mid = 1'b0;
    cds_exec dut_u (.core_clk(core_clk), .resetn(resetn), .instr_in(instr_in),
        .phase_out(phase_out), .state_out(state_out), .instr_done(instr_done),
        .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic end_sim;
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // mid means we sit mid-slot; realign to the edge that opens phase one
    task automatic rd(input logic [6:0] a);
        if (mid) repeat (3) @(posedge core_clk);
        file_rd_addr <= a;
        @(posedge core_clk);
        @(negedge core_clk);
        f = file_rd_data;
        mid = 1'b1;
    endtask
    // ch keeps the next word back to back, else an idle slot lets the file settle
    task automatic op(input logic [5:0] o, input logic d, input logic [6:0] a, input bit ch);
        if (mid) repeat (3) @(posedge core_clk);
        instr_in <= '{{o, d, a}, 1'b1};
        file_rd_addr <= a;
        repeat (4) @(posedge core_clk);
        mid = !ch;
        if (!ch) begin
            instr_in <= '0;
            @(posedge core_clk);
            @(negedge core_clk);
        end
    endtask
    task automatic t_cmpl;
        rd(7'h7F);
        `CK("acc", 8'h00, state_out.acc)
        op(6'h09, 1'b0, 7'h7F, 1'b0);
        `CK("acc", ~f, state_out.acc)
        `CK("zero", (~f == 8'h00), state_out.zero)
        `CK("file", f, file_rd_data)
        rd(7'h00);
        a0 = state_out.acc;
        op(6'h09, 1'b1, 7'h00, 1'b0);
        `CK("file", ~f, file_rd_data)
        `CK("acc", a0, state_out.acc)
    endtask
    // count the file down to one; nonzero results never skip
    task automatic t_count;
        for (int i = 0; i < 256 && file_rd_data !== 8'h01; i++) op(6'h0B, 1'b1, 7'h00, 1'b0);
        `CK("file", 8'h01, file_rd_data)
    endtask
    task automatic t_skip;
        a0 = state_out.acc;
        z = state_out.zero;
        op(6'h0B, 1'b1, 7'h00, 1'b1);
        op(6'h09, 1'b0, 7'h00, 1'b0);
        `CK("file", 8'h00, file_rd_data)
        `CK("acc", a0, state_out.acc)
        `CK("zero", z, state_out.zero)
    endtask
    task automatic t_noskip;
        op(6'h0B, 1'b0, 7'h00, 1'b1);
        op(6'h09, 1'b1, 7'h00, 1'b0);
        `CK("acc", 8'hFF, state_out.acc)
        `CK("file", 8'hFF, file_rd_data)
        `CK("zero", 1'b0, state_out.zero)
        op(6'h09, 1'b0, 7'h00, 1'b0);
        `CK("acc", 8'h00, state_out.acc)
        `CK("zero", 1'b1, state_out.zero)
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        t_cmpl();
        t_count();
        t_skip();
        t_noskip();
        end_sim();
    end
    // a hang counts as a mismatch
    initial begin
        #1000000;
        err_total++;
        end_sim();
    end
endmodule
bind cds_exec cds_exec_chk chk_u (.core_clk(core_clk), .resetn(resetn), .instr_in(instr_in),
    .phase_out(phase_out), .state_out(state_out), .instr_done(instr_done),
    .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr));
`default_nettype wire
